// *** hdl/lcr_regs_defs.vh ***
`ifndef LCR_REGS_DEFS_VH
`define LCR_REGS_DEFS_VH

// ==========================================================
// Register byte offsets
`define LCR_OFF_LINK_CTRL      12'h0D0
`define LCR_OFF_REMAP_CTRL     12'h0E4
`define LCR_OFF_REMAP_UPPER    12'h0E8

// ==========================================================
// Link control low byte fields
`define LCR_LC_EXT_SYNC        7
`define LCR_LC_SHARED_REFCLK   6
`define LCR_LC_RETRAIN         5
`define LCR_LC_LINK_DISABLE    4
`define LCR_LC_RCB             3
`define LCR_LC_RSVD            2
`define LCR_LC_ASPM_HI         1
`define LCR_LC_ASPM_LO         0
`define LCR_ASPM_DISABLED      2'h0
`define LCR_ASPM_L0S           2'h1

// ==========================================================
// Remap control fields
`define LCR_RC_LBASE_HI        31
`define LCR_RC_LBASE_LO        20
`define LCR_RC_IOSIZE_HI       12
`define LCR_RC_IOSIZE_LO       8
`define LCR_RC_REMAP_EN        3

// ==========================================================
// Reset values
`define LCR_RST_LINK_CTRL      8'h00
`define LCR_RST_LBASE          12'h000
`define LCR_RST_IOSIZE         5'h00
`define LCR_RST_REMAP_EN       1'h0
`define LCR_RST_UPPER          32'h00000000

// ==========================================================
// Exit latency encodings reported to the capability logic
`define LCR_L0S_EXIT_ASYNC     3'h4
`define LCR_L0S_EXIT_COMMON    3'h2
`define LCR_L1_EXIT_ASYNC      3'h6
`define LCR_L1_EXIT_COMMON     3'h5

`endif

// *** hdl/lcr_regs.v ***
// Notes on behaviour
// - Extended sync bit resets zero; one lengthens sync for link analyzers.
// - Common clock bit is read/write, resets zero; one selects shared refclk.
// - Reported L0s and L1 exit latencies follow the common clock bit.
// - Retrain and link disable bits read zero; writes ignored.
// - Reserved bit two of link control low byte reads zero.
// - Completion boundary bit read/write, resets zero; zero 64, one 128 bytes.
// - Two-bit power state control read/write, reset 00; 10 and 11 unsupported.
// - Five-bit downstream I/O size field read/write, resets zero.
// - Non-prefetchable remap enable read/write, resets zero.
// - Full 32-bit upper base register read/write, resets zero.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lcr_regs_defs.vh"

module lcr_regs
(
	input  wire        clock,
	input  wire        arst_n,
	input  wire        clkEn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	output wire        extSyncEn,
	output wire        sharedRefclkSelect,
	output wire        readCompletionBoundary,
	output wire [1:0]  linkPowerStateControl,
	output wire        l0sEntryEnable,
	output wire [2:0]  l0sExitLatency,
	output wire [2:0]  l1ExitLatency,
	output wire [4:0]  ioSize,
	output wire        nonprefetchRemapEnable,
	output wire [11:0] secondaryLowerBase,
	output wire [31:0] secondaryUpperBase
);

	// ==========================================================
	// Register state
	reg        extSync_reg;
	reg        sharedRefclk_reg;
	reg        rcb_reg;
	reg [1:0]  aspm_reg;
	reg [11:0] lowerBase_reg;
	reg [4:0]  ioSize_reg;
	reg        remapEn_reg;
	reg [31:0] upperBase_reg;

	wire       access;
	wire       wrEn;
	wire       hitLink;
	wire       hitCtrl;
	wire       hitUpper;
	reg [31:0] rdMux;

	// Single-cycle access phase: no wait states, so pready is a constant high
	assign pready  = 1'b1;
	assign access  = psel & penable & clkEn;
	assign wrEn    = access & pwrite;
	assign hitLink = (paddr == `LCR_OFF_LINK_CTRL);
	assign hitCtrl = (paddr == `LCR_OFF_REMAP_CTRL);
	assign hitUpper = (paddr == `LCR_OFF_REMAP_UPPER);
	// Unmapped addresses answer with an error, read data zero
	assign pslverr = psel & penable & ~(hitLink | hitCtrl | hitUpper);

	// ==========================================================
	// Byte-lane merge, used by every writable register
	function [31:0] merge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0]  lanes;
		integer i;
		begin
			merge = oldVal;
			for (i = 0; i < 4; i = i + 1)
				if (lanes[i])
					merge[i*8 +: 8] = newVal[i*8 +: 8];
		end
	endfunction

	wire [31:0] linkWord;
	wire [31:0] ctrlWord;
	wire [31:0] linkMerged;
	wire [31:0] ctrlMerged;

	// Bits 5, 4 and 2 are tied low, so written values never land anywhere
	assign linkWord = {24'h000000, extSync_reg, sharedRefclk_reg, 1'b0, 1'b0,
		rcb_reg, 1'b0, aspm_reg};
	assign ctrlWord = {lowerBase_reg, 7'h00, ioSize_reg, 4'h0, remapEn_reg,
		3'h0};
	assign linkMerged = merge(linkWord, pwdata, pstrb);
	assign ctrlMerged = merge(ctrlWord, pwdata, pstrb);

	// ==========================================================
	// Register writes
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			extSync_reg      <= 1'b0;
			sharedRefclk_reg <= 1'b0;
			rcb_reg          <= 1'b0;
			aspm_reg         <= `LCR_ASPM_DISABLED;
			lowerBase_reg    <= `LCR_RST_LBASE;
			ioSize_reg       <= `LCR_RST_IOSIZE;
			remapEn_reg      <= `LCR_RST_REMAP_EN;
			upperBase_reg    <= `LCR_RST_UPPER;
		end
		else if (wrEn)
		begin
			if (hitLink)
			begin
				extSync_reg      <= linkMerged[`LCR_LC_EXT_SYNC];
				sharedRefclk_reg <= linkMerged[`LCR_LC_SHARED_REFCLK];
				rcb_reg          <= linkMerged[`LCR_LC_RCB];
				aspm_reg         <= linkMerged[`LCR_LC_ASPM_HI:`LCR_LC_ASPM_LO];
			end
			else if (hitCtrl)
			begin
				lowerBase_reg <= ctrlMerged[`LCR_RC_LBASE_HI:`LCR_RC_LBASE_LO];
				ioSize_reg    <= ctrlMerged[`LCR_RC_IOSIZE_HI:`LCR_RC_IOSIZE_LO];
				remapEn_reg   <= ctrlMerged[`LCR_RC_REMAP_EN];
			end
			else if (hitUpper)
			begin
				upperBase_reg <= merge(upperBase_reg, pwdata, pstrb);
			end
		end
	end

	// ==========================================================
	// Read path
	always @*
	begin
		if (hitLink)
			rdMux = linkWord;
		else if (hitCtrl)
			rdMux = ctrlWord;
		else if (hitUpper)
			rdMux = upperBase_reg;
		else
			rdMux = 32'h00000000;
	end

	// Registered read data, loaded during setup so it is valid in the access cycle
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h00000000;
		else if (clkEn & psel & ~penable & ~pwrite)
			prdata <= rdMux;
	end

	// ==========================================================
	// Block outputs
	assign extSyncEn              = extSync_reg;
	assign sharedRefclkSelect     = sharedRefclk_reg;
	assign readCompletionBoundary = rcb_reg;
	assign linkPowerStateControl  = aspm_reg;
	// Reserved encodings 10 and 11 do not enable anything
	assign l0sEntryEnable = (aspm_reg == `LCR_ASPM_L0S);
	// Retraining after a change is software's job; latency just tracks the bit
	assign l0sExitLatency = sharedRefclk_reg ? `LCR_L0S_EXIT_COMMON
		: `LCR_L0S_EXIT_ASYNC;
	assign l1ExitLatency  = sharedRefclk_reg ? `LCR_L1_EXIT_COMMON
		: `LCR_L1_EXIT_ASYNC;
	assign ioSize                 = ioSize_reg;
	assign nonprefetchRemapEnable = remapEn_reg;
	assign secondaryLowerBase     = lowerBase_reg;
	assign secondaryUpperBase     = upperBase_reg;

endmodule

`default_nettype wire

// *** testbench/lcr_regs_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// Register checks
module lcr_regs_sva
(
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        clkEn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        extSyncEn,
	input wire logic        sharedRefclkSelect,
	input wire logic [1:0]  linkPowerStateControl,
	input wire logic        l0sEntryEnable,
	input wire logic [2:0]  l0sExitLatency,
	input wire logic [2:0]  l1ExitLatency,
	input wire logic [31:0] secondaryUpperBase
);
default clocking @(posedge clock); endclocking
default disable iff (!arst_n);
sequence s_wr(a, s);
	psel && !penable && pwrite && paddr == a ##1 psel && penable && clkEn && pstrb == s;
endsequence
sequence s_rd(a);
	psel && !penable && !pwrite && clkEn && paddr == a;
endsequence
property p_ctlWrite;
	s_wr(12'h0D0, 4'h1) |=> {sharedRefclkSelect, linkPowerStateControl}
		== {$past(pwdata[6]), $past(pwdata[1:0])};
endproperty
a_ctlWrite: assert property (p_ctlWrite) else $error("link write lost");
property p_upWrite;
	s_wr(12'h0E8, 4'hF) |=> secondaryUpperBase == $past(pwdata);
endproperty
a_upWrite: assert property (p_upWrite) else $error("upper write lost");
property p_upHold;
	!(psel && penable && pwrite && clkEn && paddr == 12'h0E8) |=> $stable(secondaryUpperBase);
endproperty
a_upHold: assert property (p_upHold) else $error("upper changed");
property p_ctlRead;
	s_rd(12'h0D0) |=> prdata[5:4] == 2'h0 && !prdata[2] && prdata[6] == sharedRefclkSelect;
endproperty
a_ctlRead: assert property (p_ctlRead) else $error("link read bad");
property p_rmRead;
	s_rd(12'h0E4) |=> prdata[19:13] == 7'h00 && prdata[7:4] == 4'h0 && prdata[2:0] == 3'h0;
endproperty
a_rmRead: assert property (p_rmRead) else $error("reserved bits set");
property p_latency;
	l0sExitLatency == (sharedRefclkSelect ? 3'h2 : 3'h4)
		&& l1ExitLatency == (sharedRefclkSelect ? 3'h5 : 3'h6);
endproperty
a_latency: assert property (p_latency) else $error("latency wrong");
property p_l0s;
	l0sEntryEnable == (linkPowerStateControl == 2'h1);
endproperty
a_l0s: assert property (p_l0s) else $error("entry enable wrong");
property p_rstClr;
	$rose(arst_n) |-> !extSyncEn && !sharedRefclkSelect && secondaryUpperBase == 32'h0;
endproperty
a_rstClr: assert property (p_rstClr) else $error("reset value wrong");
endmodule
bind lcr_regs lcr_regs_sva lcr_regs_sva_inst (.clock(clock), .arst_n(arst_n), .clkEn(clkEn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .extSyncEn(extSyncEn),
	.sharedRefclkSelect(sharedRefclkSelect), .linkPowerStateControl(linkPowerStateControl),
	.l0sEntryEnable(l0sEntryEnable), .l0sExitLatency(l0sExitLatency),
	.l1ExitLatency(l1ExitLatency), .secondaryUpperBase(secondaryUpperBase));
`default_nettype wire

// *** testbench/lcr_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module lcr_regs_tb;
logic clock = 0, arst_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, err, ce = 1;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, rd;
logic [3:0] pstrb = 4'h0;
wire logic pready, pslverr, extSyncEn, sharedRefclkSelect, readCompletionBoundary;
wire logic l0sEntryEnable, nonprefetchRemapEnable;
wire logic [31:0] prdata, secondaryUpperBase;
wire logic [1:0] linkPowerStateControl;
wire logic [2:0] l0sExitLatency, l1ExitLatency;
wire logic [4:0] ioSize;
wire logic [11:0] secondaryLowerBase;
int failures = 0, checks = 0;
lcr_regs lcr_regs_inst (.clock(clock), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .extSyncEn(extSyncEn),
	.sharedRefclkSelect(sharedRefclkSelect), .readCompletionBoundary(readCompletionBoundary),
	.linkPowerStateControl(linkPowerStateControl), .l0sEntryEnable(l0sEntryEnable),
	.l0sExitLatency(l0sExitLatency), .l1ExitLatency(l1ExitLatency), .ioSize(ioSize),
	.nonprefetchRemapEnable(nonprefetchRemapEnable),
	.secondaryLowerBase(secondaryLowerBase), .secondaryUpperBase(secondaryUpperBase));
always #25 clock = ~clock;
task chk(input logic [31:0] seen, input logic [31:0] exp);
	checks++;
	if (seen !== exp)
	begin
		failures++;
		$display("unexpected %0t seen %h wanted %h", $time, seen, exp);
	end
endtask
task summarize;
	$display("checks %0d failures %0d", checks, failures);
	if (failures == 0 && checks > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
	@(posedge clock);
	{psel, pwrite, paddr, pwdata, pstrb, clkEn} <= {1'h1, w, a, d, s, ce};
	@(posedge clock);
	penable <= 1;
	do @(posedge clock); while (pready !== 1'h1);
	rd = prdata;
	err = pslverr;
	{psel, penable} <= 2'h0;
	@(negedge clock);
endtask
task rdchk(input logic [11:0] a, input logic [31:0] e);
	apb(0, a, 32'h0, 4'h0);
	chk(rd, e);
endtask
task t_link;
	apb(1, 12'h0D0, 32'hFFFFFFFF, 4'h1);
	rdchk(12'h0D0, 32'h000000CB);
	chk({extSyncEn, sharedRefclkSelect, readCompletionBoundary, l0sExitLatency}, 6'h3A);
	for (int m = 0; m < 4; m++)
	begin
		apb(1, 12'h0D0, 32'(m), 4'h1);
		chk({linkPowerStateControl, l0sEntryEnable}, {m[1:0], m == 1});
	end
	chk({l1ExitLatency, sharedRefclkSelect}, 4'hC);
endtask
task t_remap;
	apb(1, 12'h0E4, 32'hFFFFFFFF, 4'hF);
	rdchk(12'h0E4, 32'hFFF01F08);
	chk({secondaryLowerBase, ioSize, nonprefetchRemapEnable}, 18'h3FFFF);
	apb(1, 12'h0E4, 32'h0, 4'h2);
	rdchk(12'h0E4, 32'hFFF00008);
endtask
task t_upper;
	apb(1, 12'h0E8, 32'hA5C30F1E, 4'hF);
	apb(1, 12'h0E8, 32'h0, 4'h1);
	rdchk(12'h0E8, 32'hA5C30F00);
	ce = 0;
	apb(1, 12'h0E8, 32'h0, 4'hF);
	ce = 1;
	apb(1, 12'h0EC, 32'h1, 4'hF);
	rdchk(12'h0DC, 32'h0);
	chk({err, secondaryUpperBase}, 33'h1A5C30F00);
	chk({pready, err}, 2'h3);
	@(posedge clock);
	arst_n <= 0;
	@(negedge clock);
	chk({secondaryUpperBase, ioSize}, 37'h0);
	@(posedge clock);
	arst_n <= 1;
	rdchk(12'h0D0, 32'h0);
endtask
initial
begin
	repeat (16) @(posedge clock);
	arst_n <= 1;
	rdchk(12'h0E4, 32'h0);
	t_link;
	t_remap;
	t_upper;
	summarize;
end
// Generous bound: the sequence needs well under 200 cycles
initial
begin
	#100000;
	failures++;
	summarize;
end
endmodule
`default_nettype wire
